// *** bench/bkr_regfile_sva.sv ***
// Purpose: port checks on status word, reads and jump query
// Assumes: flags JF ZF CF HF sit above the bank selector
// Notes: bound into every bkr_regfile instance
`timescale 1ns/1ps
`include "bkr_map.vh"
module bkr_regfile_sva #(
  parameter BANKS = 16
) (
  // Clock and reset
  input wire CLK_I,
  input wire SRST_I,
  // Stimulus
  input wire OP_EN_I,
  input wire [4:0] OP_CODE_I,
  input wire INT_ACCEPT_I,
  input wire INT_RETURN_I,
  input wire [7:0] INT_RESTORE_I,
  input wire MEM_WE_I,
  input wire [15:0] MEM_ADDR_I,
  input wire [7:0] MEM_WDATA_I,
  input wire [1:0] JMP_CC_I,
  // Results
  input wire [7:0] MEM_RDATA_O,
  input wire JMP_TAKE_O,
  input wire [7:0] PSW_O,
  input wire [7:0] PSW_PUSH_O,
  input wire PSW_PUSH_VLD_O
);
  // ****
  // Properties
  // ****
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  // Memory write to status word, cycles that leave its bank bits alone
  wire psw_wr = MEM_WE_I && MEM_ADDR_I == `BKR_PSW_ADDR;
  wire quiet = !psw_wr && !INT_RETURN_I;
  property p_rst;
    disable iff (1'b0) SRST_I |=> PSW_O == 8'h00 && !PSW_PUSH_VLD_O;
  endproperty
  property p_wr;
    psw_wr && !INT_RETURN_I |=> PSW_O[7] && (PSW_O & 8'h7f) ==
      (($past(PSW_O) & 8'h70) | ($past(MEM_WDATA_I) & 8'h0f));
  endproperty
  property p_ret;
    INT_RETURN_I |=> PSW_O == $past(INT_RESTORE_I);
  endproperty
  property p_push;
    INT_ACCEPT_I && !OP_EN_I && quiet |=>
      PSW_PUSH_VLD_O && PSW_PUSH_O == $past(PSW_O);
  endproperty
  property p_jmp;
    JMP_TAKE_O == (JMP_CC_I == `BKR_CC_T ? PSW_O[7] :
      JMP_CC_I == `BKR_CC_F ? !PSW_O[7] :
      JMP_CC_I == `BKR_CC_Z ? PSW_O[6] : PSW_O[5]);
  endproperty
  property p_rd;
    MEM_ADDR_I == `BKR_PSW_ADDR && !MEM_WE_I && !OP_EN_I && quiet
      |=> MEM_RDATA_O == PSW_O;
  endproperty
  property p_unm;
    MEM_ADDR_I > `BKR_BANK_TOP || MEM_ADDR_I < `BKR_PSW_ADDR
      |=> MEM_RDATA_O == 8'h00;
  endproperty
  property p_cf;
    OP_EN_I && quiet && (OP_CODE_I == `BKR_OP_SETCF ||
      OP_CODE_I == `BKR_OP_CLRCF) |=>
      PSW_O[5] == ($past(OP_CODE_I) == `BKR_OP_SETCF);
  endproperty
  property p_bank;
    quiet |=> $stable(PSW_O[3:0]);
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  a_wr: assert property (p_wr) else $error("bad psw write");
  a_ret: assert property (p_ret) else $error("bad restore");
  a_push: assert property (p_push) else $error("bad push");
  a_jmp: assert property (p_jmp) else $error("bad jump");
  a_rd: assert property (p_rd) else $error("bad psw read");
  a_unm: assert property (p_unm) else $error("bad read");
  a_cf: assert property (p_cf) else $error("bad carry op");
  a_bank: assert property (p_bank) else $error("bank moved");
  // Main scenarios
  c_acc: cover property (INT_ACCEPT_I);
  c_wr: cover property (psw_wr);
  c_div: cover property (OP_EN_I && OP_CODE_I == `BKR_OP_DIV);
endmodule // bkr_regfile_sva

bind bkr_regfile bkr_regfile_sva #(.BANKS(BANKS)) i_bkr_regfile_sva (
  .CLK_I, .SRST_I, .OP_EN_I, .OP_CODE_I, .INT_ACCEPT_I, .INT_RETURN_I,
  .INT_RESTORE_I, .MEM_WE_I, .MEM_ADDR_I, .MEM_WDATA_I, .JMP_CC_I,
  .MEM_RDATA_O, .JMP_TAKE_O, .PSW_O, .PSW_PUSH_O, .PSW_PUSH_VLD_O
);

// *** bench/tb.sv ***
// Purpose: self-checking bench for the banked register file
// Assumes: bank 0 after reset; inputs change on the falling edge
// Notes: ordinary ops from a table, the rest by hand
`timescale 1ns/1ps
`include "bkr_map.vh"
module tb;
  // ****
  // Signals and design
  // ****
  logic clk = 1'b0, srst = 1'b1, op_en = 1'b0, use_imm = 1'b0;
  logic ptr_sec = 1'b0, int_acc = 1'b0, int_ret = 1'b0, we = 1'b0;
  logic [4:0] op_code = 5'h00;
  logic [2:0] op_dst = 3'h0, op_src = 3'h0, op_bit = 3'h0;
  logic [1:0] ptr_mode = 2'h0, cc = 2'h0;
  logic [15:0] imm = 16'h0000, addr = 16'h0000;
  logic [7:0] int_val = 8'h00, wdata = 8'h00;
  wire [7:0] rdata, program_status_word, push;
  wire take, push_vld;
  wire [15:0] ptr_addr, wa;
  int checks = 0, miscompares = 0, cyc = 0;
  logic [43:0] r;
  // Rows: op, carry in or bit, dst, src, dst after, flags, flag mask
  logic [43:0] rows [0:24] = '{
    44'h01_0_19_28_41_1_f,
    44'h01_0_f0_10_00_e_f,
    44'h02_1_9a_d7_72_b_f,
    44'h04_1_9a_d7_c2_a_f,
    44'h03_0_30_01_2f_1_f,
    44'h05_0_9a_d7_9a_2_f,
    44'h06_0_9a_d7_92_0_c,
    44'h07_0_00_00_00_c_c,
    44'h08_0_5a_5a_00_c_c,
    44'h09_0_12_00_00_c_c,
    44'h0a_0_ff_00_00_c_c,
    44'h0b_0_00_00_ff_8_c,
    44'h0c_0_81_00_02_a_e,
    44'h0d_0_01_00_00_e_e,
    44'h0e_1_9a_00_35_a_e,
    44'h0f_0_35_00_1a_a_e,
    44'h10_5_9a_00_ba_c_c,
    44'h11_7_9a_00_1a_0_c,
    44'h12_0_9a_00_9b_c_c,
    44'h13_0_10_20_02_0_c,
    44'h13_0_0f_0f_00_c_c,
    44'h17_0_33_00_33_2_2,
    44'h18_1_33_00_33_0_2,
    44'h19_1_33_00_33_0_2,
    44'h1d_2_9a_00_9a_c_c
  };
  bkr_regfile #(.BANKS(16)) i_bkr_regfile (
    .CLK_I(clk), .SRST_I(srst), .OP_EN_I(op_en), .OP_CODE_I(op_code),
    .OP_DST_I(op_dst), .OP_SRC_I(op_src), .OP_USE_IMM_I(use_imm),
    .OP_IMM_I(imm), .OP_BIT_I(op_bit), .OP_PTR_MODE_I(ptr_mode),
    .OP_PTR_SEC_I(ptr_sec), .INT_ACCEPT_I(int_acc), .INT_RETURN_I(int_ret),
    .INT_RESTORE_I(int_val), .MEM_WE_I(we), .MEM_ADDR_I(addr),
    .MEM_WDATA_I(wdata), .MEM_RDATA_O(rdata), .JMP_CC_I(cc),
    .JMP_TAKE_O(take), .PSW_O(program_status_word), .PSW_PUSH_O(push),
    .PSW_PUSH_VLD_O(push_vld), .PTR_ADDR_O(ptr_addr), .WA_O(wa)
  );
  // ****
  // Tasks
  // ****
  task automatic summarize;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] g, e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk8(input logic [7:0] g, e);
    chk16({8'h00, g}, {8'h00, e});
  endtask
  task automatic fl(input logic [3:0] f, m);
    chk8({4'h0, program_status_word[7:4] & m}, {4'h0, f & m});
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk) {we, addr, wdata} = {1'b1, a, d};
    @(negedge clk) we = 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk) addr = a;
    @(negedge clk) chk8(rdata, e);
  endtask
  task automatic op(input logic [4:0] c, input logic [2:0] d, s);
    @(negedge clk) {op_en, op_code, op_dst, op_src} = {1'b1, c, d, s};
    @(negedge clk) op_en = 1'b0;
  endtask
  task automatic dv(input logic [7:0] w, a, c, input logic [3:0] f, m);
    wr(16'h0040, w);
    wr(16'h0041, a);
    wr(16'h0043, c);
    op(`BKR_OP_DIV, 3'h0, 3'h0);
    fl(f, m);
    @(negedge clk);
  endtask
  task automatic pt(input logic [1:0] m, input logic s, u,
                    input logic [7:0] d, input logic [15:0] e);
    {ptr_mode, ptr_sec, use_imm, imm} = {m, s, u, 8'h00, d};
    op(`BKR_OP_PTR, 3'h0, 3'h0);
    chk16(ptr_addr, e);
  endtask
  task automatic jt(input logic [3:0] e);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk) cc = i[1:0];
      #1 chk8({7'h00, take}, {7'h00, e[i]});
    end
  endtask
  // ****
  // Clock, timeout and tests
  // ****
  // Free-running 100 MHz clock
  always #5 clk = ~clk;
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk8(program_status_word, 8'h00);
    chk8({7'h00, push_vld}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 25; i++) begin
      r = rows[i];
      wr(16'h0041, r[31:24]);
      wr(16'h0042, r[23:16]);
      op_bit = r[34:32];
      op(r[32] ? `BKR_OP_SETCF : `BKR_OP_CLRCF, 3'h0, 3'h0);
      op(r[40:36], `BKR_REG_A, `BKR_REG_B);
      rdc(16'h0041, r[15:8]);
      fl(r[7:4], r[3:0]);
    end
    $display("test table done");
    wr(16'h0041, 8'h19);
    wr(16'h0042, 8'h28);
    op(`BKR_OP_ADD, `BKR_REG_A, `BKR_REG_B);
    op(`BKR_OP_DAA, `BKR_REG_A, 3'h0);
    rdc(16'h0041, 8'h47);
    op(`BKR_OP_SUB, `BKR_REG_A, `BKR_REG_B);
    op(`BKR_OP_DAS, `BKR_REG_A, 3'h0);
    rdc(16'h0041, 8'h19);
    wr(16'h0045, 8'h50);
    wr(16'h0041, 8'h10);
    op(`BKR_OP_SUB, `BKR_REG_E, `BKR_REG_A);
    rdc(16'h0045, 8'h40);
    $display("test adjust done");
    dv(8'h01, 8'h2c, 8'h07, 4'h0, 4'he);
    chk16(wa, 16'h062a);
    dv(8'h07, 8'h00, 8'h07, 4'ha, 4'ha);
    dv(8'h06, 8'hff, 8'h07, 4'h0, 4'he);
    chk16(wa, 16'h06ff);
    dv(8'h00, 8'h0e, 8'h07, 4'h4, 4'he);
    dv(8'h12, 8'h34, 8'h00, 4'ha, 4'ha);
    wr(16'h0040, 8'h21);
    wr(16'h0041, 8'h9a);
    {use_imm, imm} = {1'b1, 16'hf508};
    op(`BKR_OP_ADDW, 3'h0, 3'h0);
    fl(4'ha, 4'he);
    @(negedge clk) chk16(wa, 16'h16a2);
    imm = 16'h16a2;
    op(`BKR_OP_SUBW, 3'h0, 3'h0);
    fl(4'h4, 4'he);
    $display("test divide done");
    wr(16'h0046, 8'h12);
    wr(16'h0047, 8'h34);
    wr(16'h0043, 8'h05);
    wr(16'h0044, 8'hab);
    wr(16'h0045, 8'hcd);
    pt(`BKR_PTR_PLAIN, 1'b0, 1'b0, 8'h00, 16'h1234);
    pt(`BKR_PTR_DISP, 1'b0, 1'b0, 8'hfe, 16'h1232);
    pt(`BKR_PTR_POSTINC, 1'b0, 1'b0, 8'h00, 16'h1234);
    pt(`BKR_PTR_PREDEC, 1'b0, 1'b0, 8'h00, 16'h1234);
    pt(`BKR_PTR_PLAIN, 1'b0, 1'b1, 8'h00, 16'h1239);
    pt(`BKR_PTR_PLAIN, 1'b1, 1'b0, 8'h00, 16'habcd);
    use_imm = 1'b0;
    $display("test pointer done");
    wr(16'h0041, 8'h30);
    wr(16'h0042, 8'h01);
    op(`BKR_OP_SUB, `BKR_REG_A, `BKR_REG_B);
    jt(4'b0010);
    wr(16'h0041, 8'hf0);
    wr(16'h0042, 8'h10);
    op(`BKR_OP_ADD, `BKR_REG_A, `BKR_REG_B);
    jt(4'b1101);
    wr(`BKR_PSW_ADDR, 8'h05);
    chk8(program_status_word, 8'he5);
    rdc(`BKR_PSW_ADDR, 8'he5);
    $display("test jump done");
    @(negedge clk) int_acc = 1'b1;
    @(negedge clk) int_acc = 1'b0;
    chk8(push, 8'he5);
    chk8({7'h00, push_vld}, 8'h01);
    wr(`BKR_PSW_ADDR, 8'h02);
    chk8(program_status_word, 8'he2);
    @(negedge clk) {int_ret, int_val} = {1'b1, 8'he5};
    @(negedge clk) int_ret = 1'b0;
    chk8(program_status_word, 8'he5);
    {use_imm, imm} = {1'b1, 16'h005c};
    op(`BKR_OP_LD, `BKR_REG_A, 3'h0);
    rdc(16'h0069, 8'h5c);
    rdc(16'h0041, 8'h00);
    rdc(16'h0100, 8'h00);
    $display("test bank done");
    @(negedge clk) srst = 1'b1;
    @(negedge clk) srst = 1'b0;
    chk8(program_status_word, 8'h00);
    $display("test second reset done");
    summarize();
  end
endmodule // tb

// *** rtl/bkr_map.vh ***
// Purpose: constants for the banked register file and status word
// Assumes: 8-bit data, 16-bit data addresses
// Notes: included by bkr_regfile.v
`ifndef BKR_MAP_VH
`define BKR_MAP_VH
`define BKR_PSW_ADDR 16'h003f
`define BKR_BANK_BASE 16'h0040
`define BKR_BANK_TOP 16'h00bf
`define BKR_PSW_RESET 8'h00
`define BKR_BIT_JF 7
`define BKR_BIT_ZF 6
`define BKR_BIT_CF 5
`define BKR_BIT_HF 4
`define BKR_REG_W 3'h0
`define BKR_REG_A 3'h1
`define BKR_REG_B 3'h2
`define BKR_REG_C 3'h3
`define BKR_REG_D 3'h4
`define BKR_REG_E 3'h5
`define BKR_REG_H 3'h6
`define BKR_REG_L 3'h7
`define BKR_OP_NOP 5'h00
`define BKR_OP_ADD 5'h01
`define BKR_OP_ADDC 5'h02
`define BKR_OP_SUB 5'h03
`define BKR_OP_SUBB 5'h04
`define BKR_OP_CMP 5'h05
`define BKR_OP_AND 5'h06
`define BKR_OP_OR 5'h07
`define BKR_OP_XOR 5'h08
`define BKR_OP_LD 5'h09
`define BKR_OP_INC 5'h0a
`define BKR_OP_DEC 5'h0b
`define BKR_OP_SHIFT_LEFT_THROUGH_CARRY 5'h0c
`define BKR_OP_SHIFT_RIGHT_THROUGH_CARRY 5'h0d
`define BKR_OP_ROTATE_LEFT_CARRY 5'h0e
`define BKR_OP_ROTATE_RIGHT_CARRY 5'h0f
`define BKR_OP_SETB 5'h10
`define BKR_OP_CLRB 5'h11
`define BKR_OP_CPLB 5'h12
`define BKR_OP_MUL 5'h13
`define BKR_OP_DIV 5'h14
`define BKR_OP_DAA 5'h15
`define BKR_OP_DAS 5'h16
`define BKR_OP_SETCF 5'h17
`define BKR_OP_CLRCF 5'h18
`define BKR_OP_CPLCF 5'h19
`define BKR_OP_ADDW 5'h1a
`define BKR_OP_SUBW 5'h1b
`define BKR_OP_PTR 5'h1c
`define BKR_OP_TEST 5'h1d
`define BKR_PTR_PLAIN 2'h0
`define BKR_PTR_DISP 2'h1
`define BKR_PTR_POSTINC 2'h2
`define BKR_PTR_PREDEC 2'h3
`define BKR_CC_T 2'h0
`define BKR_CC_F 2'h1
`define BKR_CC_Z 2'h2
`define BKR_CC_C 2'h3
`endif

// *** rtl/bkr_regfile.v ***
// Purpose: banked register file with status word and flag logic
// Assumes: one op per cycle from the core sequencer; single clock
// Notes: registers live in a 128-byte array also seen as data memory
`timescale 1ns/1ps
`include "bkr_map.vh"

module bkr_regfile #(
  parameter BANKS = 16
) (
  // Clock and reset
  input wire CLK_I,
  input wire SRST_I,
  // Operation request
  input wire OP_EN_I,
  input wire [4:0] OP_CODE_I,
  input wire [2:0] OP_DST_I,
  input wire [2:0] OP_SRC_I,
  input wire OP_USE_IMM_I,
  input wire [15:0] OP_IMM_I,
  input wire [2:0] OP_BIT_I,
  input wire [1:0] OP_PTR_MODE_I,
  input wire OP_PTR_SEC_I,
  // Interrupt save and restore
  input wire INT_ACCEPT_I,
  input wire INT_RETURN_I,
  input wire [7:0] INT_RESTORE_I,
  // Data memory port
  input wire MEM_WE_I,
  input wire [15:0] MEM_ADDR_I,
  input wire [7:0] MEM_WDATA_I,
  output reg [7:0] MEM_RDATA_O,
  // Jump condition query
  input wire [1:0] JMP_CC_I,
  output wire JMP_TAKE_O,
  // Results
  output reg [7:0] PSW_O,
  output reg [7:0] PSW_PUSH_O,
  output reg PSW_PUSH_VLD_O,
  output reg [15:0] PTR_ADDR_O,
  output reg [15:0] WA_O
);

  // ******************************
  // Storage
  // ******************************
  reg [7:0] regs_r [0:BANKS*8-1];
  reg [3:0] bank_select_r;
  reg jf_r, zf_r, cf_r, hf_r;
  reg [3:0] bank_nxt;
  reg jf_nxt, zf_nxt, cf_nxt, hf_nxt;
  reg wr_en_nxt, wr2_en_nxt;
  reg [2:0] wr_idx_nxt, wr2_idx_nxt;
  reg [7:0] wr_dat_nxt, wr2_dat_nxt;
  reg [15:0] ptr_nxt;

  // Register index inside the array for the current bank
  function [6:0] ridx;
    input [3:0] bank;
    input [2:0] r;
    begin
      ridx = {bank, r};
    end
  endfunction

  wire [7:0] rd_dst = regs_r[ridx(bank_select_r, OP_DST_I)];
  wire [7:0] rd_src = OP_USE_IMM_I ? OP_IMM_I[7:0] :
    regs_r[ridx(bank_select_r, OP_SRC_I)];
  wire [7:0] reg_w = regs_r[ridx(bank_select_r, `BKR_REG_W)];
  wire [7:0] reg_a = regs_r[ridx(bank_select_r, `BKR_REG_A)];
  wire [7:0] reg_c = regs_r[ridx(bank_select_r, `BKR_REG_C)];
  wire [15:0] wa = {reg_w, reg_a};
  wire [15:0] hl = {regs_r[ridx(bank_select_r, `BKR_REG_H)],
    regs_r[ridx(bank_select_r, `BKR_REG_L)]};
  wire [15:0] de = {regs_r[ridx(bank_select_r, `BKR_REG_D)],
    regs_r[ridx(bank_select_r, `BKR_REG_E)]};
  wire [7:0] program_status_word = {jf_r, zf_r, cf_r, hf_r, bank_select_r};

  // Memory-view decode of the bank area
  wire mem_in_bank = (MEM_ADDR_I >= `BKR_BANK_BASE) &&
    (MEM_ADDR_I <= `BKR_BANK_TOP);
  wire [15:0] mem_off = MEM_ADDR_I - `BKR_BANK_BASE;
  wire [6:0] mem_idx = mem_off[6:0];

  // ******************************
  // Arithmetic helpers
  // ******************************
  wire cin = (OP_CODE_I == `BKR_OP_ADDC || OP_CODE_I == `BKR_OP_SUBB) ?
    cf_r : 1'b0;
  wire [8:0] add9 = {1'b0, rd_dst} + {1'b0, rd_src} + {8'h00, cin};
  wire [4:0] add5 = {1'b0, rd_dst[3:0]} + {1'b0, rd_src[3:0]} +
    {4'h0, cin};
  wire [8:0] sub9 = {1'b0, rd_dst} - {1'b0, rd_src} - {8'h00, cin};
  wire [4:0] sub5 = {1'b0, rd_dst[3:0]} - {1'b0, rd_src[3:0]} -
    {4'h0, cin};
  wire [16:0] addw = {1'b0, wa} + {1'b0, OP_IMM_I};
  wire [16:0] subw = {1'b0, wa} - {1'b0, OP_IMM_I};
  wire [16:0] wres = (OP_CODE_I == `BKR_OP_ADDW) ? addw : subw;
  wire [15:0] prod = rd_dst * rd_src;
  wire [15:0] quo = (reg_c == 8'h00) ? 16'h0000 : wa / {8'h00, reg_c};
  wire [15:0] rem = (reg_c == 8'h00) ? 16'h0000 : wa % {8'h00, reg_c};
  wire old_bit = rd_dst[OP_BIT_I];
  wire [7:0] bit_mask = 8'h01 << OP_BIT_I;
  wire [7:0] disp_ext = OP_IMM_I[7:0];
  wire [15:0] hl_disp = hl + {{8{disp_ext[7]}}, disp_ext};
  wire post_inc = (OP_PTR_MODE_I == `BKR_PTR_POSTINC);
  wire [15:0] hl_dec = hl - 16'h0001;
  wire [15:0] hl_step = post_inc ? hl + 16'h0001 : hl_dec;

  // ******************************
  // Jump condition evaluation
  // ******************************
  assign JMP_TAKE_O = (JMP_CC_I == `BKR_CC_T) ? jf_r :
    (JMP_CC_I == `BKR_CC_F) ? ~jf_r :
    (JMP_CC_I == `BKR_CC_Z) ? zf_r : cf_r;

  // ******************************
  // Operation decode
  // ******************************
  always @* begin
    bank_nxt = bank_select_r;
    jf_nxt = jf_r;
    zf_nxt = zf_r;
    cf_nxt = cf_r;
    hf_nxt = hf_r;
    wr_en_nxt = 1'b0;
    wr_idx_nxt = OP_DST_I;
    wr_dat_nxt = 8'h00;
    wr2_en_nxt = 1'b0;
    wr2_idx_nxt = `BKR_REG_W;
    wr2_dat_nxt = 8'h00;
    ptr_nxt = PTR_ADDR_O;
    if (OP_EN_I) begin
      case (OP_CODE_I)
        `BKR_OP_ADD, `BKR_OP_ADDC: begin
          wr_en_nxt = 1'b1;
          wr_dat_nxt = add9[7:0];
          cf_nxt = add9[8];
          hf_nxt = add5[4];
          zf_nxt = (add9[7:0] == 8'h00);
          jf_nxt = add9[8];
        end
        `BKR_OP_SUB, `BKR_OP_SUBB, `BKR_OP_CMP: begin
          wr_en_nxt = (OP_CODE_I != `BKR_OP_CMP);
          wr_dat_nxt = sub9[7:0];
          cf_nxt = sub9[8];
          hf_nxt = sub5[4];
          zf_nxt = (sub9[7:0] == 8'h00);
          jf_nxt = (OP_CODE_I == `BKR_OP_CMP) ? (sub9[7:0] == 8'h00) :
            sub9[8];
        end
        `BKR_OP_AND, `BKR_OP_OR, `BKR_OP_XOR: begin
          wr_en_nxt = 1'b1;
          wr_dat_nxt = (OP_CODE_I == `BKR_OP_AND) ? (rd_dst & rd_src) :
            (OP_CODE_I == `BKR_OP_OR) ? (rd_dst | rd_src) :
            (rd_dst ^ rd_src);
          zf_nxt = (wr_dat_nxt == 8'h00);
          jf_nxt = zf_nxt;
        end
        `BKR_OP_LD: begin
          wr_en_nxt = 1'b1;
          wr_dat_nxt = rd_src;
          zf_nxt = (rd_src == 8'h00);
          jf_nxt = 1'b1;
        end
        `BKR_OP_INC, `BKR_OP_DEC: begin
          wr_en_nxt = 1'b1;
          wr_dat_nxt = (OP_CODE_I == `BKR_OP_INC) ? rd_dst + 8'h01 :
            rd_dst - 8'h01;
          zf_nxt = (wr_dat_nxt == 8'h00);
          jf_nxt = (OP_CODE_I == `BKR_OP_INC) ? zf_nxt :
            (rd_dst == 8'h00);
        end
        `BKR_OP_SHIFT_LEFT_THROUGH_CARRY, `BKR_OP_ROTATE_LEFT_CARRY: begin
          wr_en_nxt = 1'b1;
          wr_dat_nxt = {rd_dst[6:0],
            (OP_CODE_I == `BKR_OP_ROTATE_LEFT_CARRY) ? cf_r : 1'b0};
          cf_nxt = rd_dst[7];
          jf_nxt = rd_dst[7];
          zf_nxt = (wr_dat_nxt == 8'h00);
        end
        `BKR_OP_SHIFT_RIGHT_THROUGH_CARRY, `BKR_OP_ROTATE_RIGHT_CARRY: begin
          wr_en_nxt = 1'b1;
          wr_dat_nxt = {(OP_CODE_I == `BKR_OP_ROTATE_RIGHT_CARRY) ? cf_r : 1'b0,
            rd_dst[7:1]};
          cf_nxt = rd_dst[0];
          jf_nxt = rd_dst[0];
          zf_nxt = (wr_dat_nxt == 8'h00);
        end
        `BKR_OP_SETB, `BKR_OP_CLRB, `BKR_OP_CPLB, `BKR_OP_TEST: begin
          wr_en_nxt = (OP_CODE_I != `BKR_OP_TEST);
          wr_dat_nxt = (OP_CODE_I == `BKR_OP_SETB) ? (rd_dst | bit_mask) :
            (OP_CODE_I == `BKR_OP_CLRB) ? (rd_dst & ~bit_mask) :
            (rd_dst ^ bit_mask);
          zf_nxt = ~old_bit;
          jf_nxt = ~old_bit;
        end
        `BKR_OP_MUL: begin
          wr_en_nxt = 1'b1;
          wr_dat_nxt = prod[15:8];
          wr2_en_nxt = 1'b1;
          wr2_idx_nxt = OP_SRC_I;
          wr2_dat_nxt = prod[7:0];
          zf_nxt = (prod[15:8] == 8'h00);
          jf_nxt = zf_nxt;
        end
        `BKR_OP_DIV: begin
          wr_en_nxt = 1'b1;
          wr_idx_nxt = `BKR_REG_A;
          wr_dat_nxt = quo[7:0];
          wr2_en_nxt = 1'b1;
          wr2_idx_nxt = `BKR_REG_W;
          wr2_dat_nxt = rem[7:0];
          zf_nxt = (rem[7:0] == 8'h00);
          cf_nxt = (reg_c == 8'h00) || (quo[15:8] != 8'h00);
          jf_nxt = cf_nxt;
        end
        `BKR_OP_DAA: begin
          wr_en_nxt = 1'b1;
          wr_dat_nxt = rd_dst;
          if (hf_r || rd_dst[3:0] > 4'h9)
            wr_dat_nxt = wr_dat_nxt + 8'h06;
          if (cf_r || wr_dat_nxt[7:4] > 4'h9 || rd_dst > 8'h99) begin
            wr_dat_nxt = wr_dat_nxt + 8'h60;
            cf_nxt = 1'b1;
          end
          zf_nxt = (wr_dat_nxt == 8'h00);
          jf_nxt = cf_nxt;
        end
        `BKR_OP_DAS: begin
          wr_en_nxt = 1'b1;
          wr_dat_nxt = rd_dst;
          if (hf_r || rd_dst[3:0] > 4'h9)
            wr_dat_nxt = wr_dat_nxt - 8'h06;
          if (cf_r || rd_dst > 8'h99) begin
            wr_dat_nxt = wr_dat_nxt - 8'h60;
            cf_nxt = 1'b1;
          end
          zf_nxt = (wr_dat_nxt == 8'h00);
          jf_nxt = cf_nxt;
        end
        `BKR_OP_SETCF: cf_nxt = 1'b1;
        `BKR_OP_CLRCF: cf_nxt = 1'b0;
        `BKR_OP_CPLCF: cf_nxt = ~cf_r;
        `BKR_OP_ADDW, `BKR_OP_SUBW: begin
          wr_en_nxt = 1'b1;
          wr_idx_nxt = `BKR_REG_A;
          wr2_en_nxt = 1'b1;
          wr2_idx_nxt = `BKR_REG_W;
          wr_dat_nxt = wres[7:0];
          wr2_dat_nxt = wres[15:8];
          cf_nxt = wres[16];
          zf_nxt = (wres[15:0] == 16'h0000);
          jf_nxt = cf_nxt;
        end
        `BKR_OP_PTR: begin
          if (OP_PTR_SEC_I)
            ptr_nxt = de;
          else if (OP_USE_IMM_I)
            ptr_nxt = {8'h00, reg_c} + hl;
          else begin
            case (OP_PTR_MODE_I)
              `BKR_PTR_PLAIN: ptr_nxt = hl;
              `BKR_PTR_DISP: ptr_nxt = hl_disp;
              default: begin
                ptr_nxt = post_inc ? hl : hl_dec;
                wr_en_nxt = 1'b1;
                wr_idx_nxt = `BKR_REG_L;
                wr_dat_nxt = hl_step[7:0];
                wr2_en_nxt = 1'b1;
                wr2_idx_nxt = `BKR_REG_H;
                wr2_dat_nxt = hl_step[15:8];
              end
            endcase
          end
        end
        default: ;
      endcase
    end
    // Memory write to the status word
    if (MEM_WE_I && MEM_ADDR_I == `BKR_PSW_ADDR) begin
      bank_nxt = MEM_WDATA_I[3:0];
      jf_nxt = 1'b1;
    end
    // Interrupt return restores the whole word
    if (INT_RETURN_I) begin
      bank_nxt = INT_RESTORE_I[3:0];
      jf_nxt = INT_RESTORE_I[`BKR_BIT_JF];
      zf_nxt = INT_RESTORE_I[`BKR_BIT_ZF];
      cf_nxt = INT_RESTORE_I[`BKR_BIT_CF];
      hf_nxt = INT_RESTORE_I[`BKR_BIT_HF];
    end
  end

  // ******************************
  // Status word state
  // ******************************
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      {jf_r, zf_r, cf_r, hf_r, bank_select_r} <= `BKR_PSW_RESET;
      PSW_PUSH_O <= `BKR_PSW_RESET;
      PSW_PUSH_VLD_O <= 1'b0;
      PTR_ADDR_O <= 16'h0000;
    end else begin
      bank_select_r <= bank_nxt;
      jf_r <= jf_nxt;
      zf_r <= zf_nxt;
      cf_r <= cf_nxt;
      hf_r <= hf_nxt;
      PSW_PUSH_VLD_O <= INT_ACCEPT_I;
      if (INT_ACCEPT_I)
        PSW_PUSH_O <= program_status_word;
      PTR_ADDR_O <= ptr_nxt;
    end
  end

  // Register array writes; memory view shares the same bytes
  always @(posedge CLK_I) begin
    if (MEM_WE_I && mem_in_bank)
      regs_r[mem_idx] <= MEM_WDATA_I;
    if (wr_en_nxt)
      regs_r[ridx(bank_select_r, wr_idx_nxt)] <= wr_dat_nxt;
    if (wr2_en_nxt)
      regs_r[ridx(bank_select_r, wr2_idx_nxt)] <= wr2_dat_nxt;
  end

  // Registered read-outs
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      MEM_RDATA_O <= 8'h00;
      PSW_O <= `BKR_PSW_RESET;
      WA_O <= 16'h0000;
    end else begin
      PSW_O <= {jf_nxt, zf_nxt, cf_nxt, hf_nxt, bank_nxt};
      WA_O <= wa;
      if (MEM_ADDR_I == `BKR_PSW_ADDR)
        MEM_RDATA_O <= program_status_word;
      else if (mem_in_bank)
        MEM_RDATA_O <= regs_r[mem_idx];
      else
        MEM_RDATA_O <= 8'h00;
    end
  end

endmodule // bkr_regfile
